// ==== bench/bpp_printer_model.sv ====
`timescale 1ns/1ns

module bpp_printer_model #(
    parameter int ACK_LEN = 4
) (
    // Clock
    input  wire logic                    hclk,
    // Data lines as the port drives them
    input  wire logic [7:0]              lines_out,
    input  wire logic                    lines_oe_n,
    output logic      [7:0]              lines_in,
    // Printer behaviour chosen by the bench
    input  wire logic                    drive_en,
    input  wire logic [7:0]              drive_val,
    input  wire bpp_pkg::bpp_status_in_t status_set,
    input  wire logic                    ack_go,
    output bpp_pkg::bpp_status_in_t      status
);
    logic [7:0] last_level = 8'h00;
    int         ack_cnt    = 0;

    // Acknowledge is a low pulse of fixed length, then released high
    always_ff @(posedge hclk) begin
        if (ack_go) begin
            ack_cnt <= ACK_LEN;
        end else if (ack_cnt > 0) begin
            ack_cnt <= ack_cnt - 1;
        end
        last_level <= lines_in;
    end

    // Undriven lines toggle every cycle so a stale value can never pass
    always_comb begin
        status       = status_set;
        status.ack_n = status_set.ack_n & (ack_cnt == 0);
        if (!lines_oe_n) begin
            lines_in = lines_out;
        end else if (drive_en) begin
            lines_in = drive_val;
        end else begin
            lines_in = ~last_level;
        end
    end
endmodule : bpp_printer_model

// ==== bench/tb.sv ====
`timescale 1ns/1ns

module tb;
    localparam logic [31:0] A_DATA = 32'(bpp_pkg::DATA_IDX) << 2;
    localparam logic [31:0] A_STAT = 32'(bpp_pkg::STATUS_IDX) << 2;
    localparam logic [31:0] A_CTRL = 32'(bpp_pkg::CONTROL_IDX) << 2;
    localparam logic [31:0] A_NONE = 32'h0000000c;

    logic                    hclk       = 1'b0;
    logic                    hresetn    = 1'b0;
    logic                    hsel       = 1'b0;
    logic [31:0]             haddr      = 32'h0;
    logic [1:0]              htrans     = 2'h0;
    logic                    hwrite     = 1'b0;
    logic [2:0]              hsize      = 3'h2;
    logic [31:0]             hwdata     = 32'h0;
    logic                    ext_mode   = 1'b0;
    logic                    drive_en   = 1'b0;
    logic [7:0]              drive_val  = 8'h00;
    logic                    ack_go     = 1'b0;
    bpp_pkg::bpp_status_in_t status_set = 5'b11010;
    bpp_pkg::bpp_status_in_t status;
    wire logic               hready;
    logic [31:0]             hrdata;
    logic                    hreadyout;
    logic                    hresp;
    logic [7:0]              lines_in;
    logic [7:0]              lines_out;
    logic                    lines_oe_n;
    logic                    strobe_n;
    logic                    feed_n;
    logic                    init_n;
    logic                    sel_in_n;
    logic                    irq_out;
    logic                    irq_oe_n;
    logic [31:0]             rd;
    int                      failures   = 0;
    int                      num_checks = 0;

    assign hready = hreadyout;

    initial begin
        forever #10 hclk = ~hclk;
    end

    bpp_port bpp_port_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .extended_mode_pin(ext_mode), .parallel_data_lines_in(lines_in),
        .parallel_data_lines_out(lines_out), .parallel_data_lines_oe_n(lines_oe_n),
        .printer_busy(status.busy), .printer_ack_n(status.ack_n), .paper_out(status.paper_out),
        .printer_selected(status.selected), .printer_fault_n(status.fault_n),
        .data_strobe_n(strobe_n), .auto_line_feed_n(feed_n), .printer_init_n(init_n),
        .select_in_line_n(sel_in_n), .port_irq_output(irq_out), .port_irq_oe_n(irq_oe_n)
    );

    bpp_printer_model bpp_printer_model_inst (
        .hclk(hclk), .lines_out(lines_out), .lines_oe_n(lines_oe_n), .lines_in(lines_in),
        .drive_en(drive_en), .drive_val(drive_val), .status_set(status_set), .ack_go(ack_go),
        .status(status)
    );

    task automatic end_of_test;
        if (failures == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask : check

    // Zero wait states are promised, but the master never relies on it
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 16);
        if (hready !== 1'b1) begin
            $display("mismatch hready expected 1 seen %b", hready);
            failures++;
            end_of_test();
        end
    endtask : wait_ready

    task automatic ahb_xfer(input logic [31:0] a, input logic wr, input logic [7:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_ready();
        rd = hrdata;
    endtask : ahb_xfer

    task automatic settle(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask : settle

    task automatic ack_pulse;
        ack_go <= 1'b1;
        @(posedge hclk);
        ack_go <= 1'b0;
        settle(10);
    endtask : ack_pulse

    task automatic test_reset;
        ahb_xfer(A_STAT, 1'b0, 8'h00);
        check("status", 32'hd7, rd);
        ahb_xfer(A_CTRL, 1'b0, 8'h00);
        check("control", 32'h00, rd);
        check("init_n", 32'h0, {31'h0, init_n});
    endtask : test_reset

    task automatic test_status_map;
        status_set <= 5'b01101;
        settle(3);
        ahb_xfer(A_STAT, 1'b0, 8'h00);
        check("status", 32'h6f, rd);
        ahb_xfer(A_STAT, 1'b1, 8'h00);
        ahb_xfer(A_STAT, 1'b0, 8'h00);
        check("status", 32'h6f, rd);
        ahb_xfer(A_NONE, 1'b1, 8'hff);
        ahb_xfer(A_NONE, 1'b0, 8'h00);
        check("unmapped", 32'h00, rd);
        check("hresp", 32'h0, {31'h0, hresp});
        status_set <= 5'b11010;
        settle(3);
    endtask : test_status_map

    task automatic test_control;
        ahb_xfer(A_CTRL, 1'b1, 8'hff);
        ahb_xfer(A_CTRL, 1'b0, 8'h00);
        check("control", 32'h3f, rd);
        check("ctrl pins", 32'h04, {27'h0, strobe_n, feed_n, init_n, sel_in_n, irq_oe_n});
        ahb_xfer(A_CTRL, 1'b1, 8'h00);
        ahb_xfer(A_CTRL, 1'b0, 8'h00);
        check("control", 32'h00, rd);
        check("ctrl pins", 32'h1b, {27'h0, strobe_n, feed_n, init_n, sel_in_n, irq_oe_n});
    endtask : test_control

    task automatic test_data;
        ahb_xfer(A_CTRL, 1'b1, 8'h20);
        drive_en  <= 1'b1;
        drive_val <= 8'h5a;
        ahb_xfer(A_DATA, 1'b1, 8'ha5);
        settle(2);
        check("lines", 32'h0a5, {23'h0, lines_oe_n, lines_out});
        ahb_xfer(A_DATA, 1'b0, 8'h00);
        check("data", 32'ha5, rd);
        ext_mode <= 1'b1;
        settle(4);
        check("oe_n", 32'h1, {31'h0, lines_oe_n});
        ahb_xfer(A_DATA, 1'b1, 8'hc3);
        ahb_xfer(A_DATA, 1'b0, 8'h00);
        check("data", 32'h5a, rd);
        ahb_xfer(A_CTRL, 1'b1, 8'h00);
        settle(2);
        check("lines", 32'h0c3, {23'h0, lines_oe_n, lines_out});
        ahb_xfer(A_DATA, 1'b0, 8'h00);
        check("data", 32'hc3, rd);
        drive_en <= 1'b0;
        ext_mode <= 1'b0;
    endtask : test_data

    task automatic test_flag;
        ahb_xfer(A_CTRL, 1'b1, 8'h10);
        settle(2);
        check("irq", 32'h0, {30'h0, irq_oe_n, irq_out});
        ack_pulse();
        check("irq", 32'h1, {30'h0, irq_oe_n, irq_out});
        ahb_xfer(A_STAT, 1'b0, 8'h00);
        check("status", 32'hd3, rd);
        ahb_xfer(A_STAT, 1'b0, 8'h00);
        check("status", 32'hd7, rd);
        check("irq", 32'h0, {31'h0, irq_out});
        ahb_xfer(A_CTRL, 1'b1, 8'h00);
        settle(2);
        check("irq oe_n", 32'h1, {31'h0, irq_oe_n});
        ack_pulse();
        ahb_xfer(A_STAT, 1'b0, 8'h00);
        check("status", 32'hd7, rd);
    endtask : test_flag

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        settle(3);
        test_reset();
        test_status_map();
        test_control();
        test_data();
        test_flag();
        end_of_test();
    end
endmodule : tb

// ==== hw/bpp_pkg.sv ====
package bpp_pkg;

    // Register indices; the byte address of each is four times its index
    localparam logic [1:0]  DATA_IDX     = 2'h0;
    localparam logic [1:0]  STATUS_IDX   = 2'h1;
    localparam logic [1:0]  CONTROL_IDX  = 2'h2;
    localparam int          IDX_LSB      = 2;
    localparam int          IDX_MSB      = 3;

    // Control register fields
    localparam int          CTRL_STROBE  = 0;
    localparam int          CTRL_FEED    = 1;
    localparam int          CTRL_INIT    = 2;
    localparam int          CTRL_SEL_IN  = 3;
    localparam int          CTRL_IRQ_EN  = 4;
    localparam int          CTRL_DIR     = 5;
    localparam logic [7:0]  CTRL_WR_MASK = 8'h3f;

    // Status register fields
    localparam int          STAT_FLAG    = 2;
    localparam logic [1:0]  STAT_FIXED   = 2'h3;

    // Values after reset
    localparam logic [7:0]  DATA_RESET   = 8'h00;
    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic        FLAG_RESET   = 1'b1;

    // Printer inputs, ordered as status bits 7 down to 3
    typedef struct packed {
        logic busy;
        logic ack_n;
        logic paper_out;
        logic selected;
        logic fault_n;
    } bpp_status_in_t;

    // Everything that crosses the synchroniser: status inputs and data lines
    typedef struct packed {
        bpp_status_in_t status;
        logic [7:0]     lines;
    } bpp_pins_t;

    typedef struct packed {
        bpp_pins_t first;
        bpp_pins_t second;
    } bpp_sync_state_t;

    typedef struct packed {
        logic [7:0]  data_reg;
        logic [7:0]  ctrl_reg;
        logic        flag_reg;
        logic        ack_prev;
        logic        ph_valid;
        logic        ph_write;
        logic [1:0]  ph_idx;
        logic [31:0] rdata;
    } bpp_state_t;

endpackage : bpp_pkg

// ==== hw/bpp_port.sv ====
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns

module bpp_port (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Mode strap
    input  wire logic        extended_mode_pin,
    // Parallel data lines
    input  wire logic [7:0]  parallel_data_lines_in,
    output logic      [7:0]  parallel_data_lines_out,
    output logic             parallel_data_lines_oe_n,
    // Printer status inputs
    input  wire logic        printer_busy,
    input  wire logic        printer_ack_n,
    input  wire logic        paper_out,
    input  wire logic        printer_selected,
    input  wire logic        printer_fault_n,
    // Printer control outputs
    output logic             data_strobe_n,
    output logic             auto_line_feed_n,
    output logic             printer_init_n,
    output logic             select_in_line_n,
    // Port interrupt, open to float
    output logic             port_irq_output,
    output logic             port_irq_oe_n
);

    bpp_pkg::bpp_state_t st_reg;
    bpp_pkg::bpp_state_t st_next;
    bpp_pkg::bpp_pins_t  pins_async;
    bpp_pkg::bpp_pins_t  pins_sync;
    logic                addr_take;
    logic                rd_take;
    logic                ack_release;

    // Word-aligned access to one of the three registers
    function automatic logic bpp_mapped(input logic [31:0] addr);
        logic [1:0] idx;
        idx = addr[bpp_pkg::IDX_MSB:bpp_pkg::IDX_LSB];
        bpp_mapped = (addr[31:4] == 28'h0000000) && (addr[1:0] == 2'h0) &&
                     (idx == bpp_pkg::DATA_IDX || idx == bpp_pkg::STATUS_IDX ||
                      idx == bpp_pkg::CONTROL_IDX);
    endfunction : bpp_mapped

    // Value seen by a read of the given index
    function automatic logic [7:0] bpp_read_value(
        input logic [1:0]          idx,
        input logic [7:0]          data_latch,
        input logic [7:0]          ctrl,
        input logic                flag,
        input logic                ext_mode,
        input bpp_pkg::bpp_pins_t  pins
    );
        bpp_read_value = 8'h00;
        case (idx)
            bpp_pkg::DATA_IDX: begin
                if (ext_mode && ctrl[bpp_pkg::CTRL_DIR]) begin
                    bpp_read_value = pins.lines;
                end else begin
                    bpp_read_value = data_latch;
                end
            end
            bpp_pkg::STATUS_IDX: begin
                bpp_read_value = {pins.status, flag, bpp_pkg::STAT_FIXED};
            end
            bpp_pkg::CONTROL_IDX: begin
                bpp_read_value = ctrl & bpp_pkg::CTRL_WR_MASK;
            end
            default: begin
                bpp_read_value = 8'h00;
            end
        endcase
    endfunction : bpp_read_value

    assign pins_async.status.busy      = printer_busy;
    assign pins_async.status.ack_n     = printer_ack_n;
    assign pins_async.status.paper_out = paper_out;
    assign pins_async.status.selected  = printer_selected;
    assign pins_async.status.fault_n   = printer_fault_n;
    assign pins_async.lines            = parallel_data_lines_in;

    // Handshake lines and data lines are all asynchronous to hclk
    bpp_sync u_sync (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .pins_async (pins_async),
        .pins_sync  (pins_sync)
    );

    assign addr_take   = hsel && hready && htrans[1];
    assign rd_take     = addr_take && !hwrite && bpp_mapped(haddr);
    // Acknowledge is active low, so its release is a rising edge
    assign ack_release = pins_sync.status.ack_n && !st_reg.ack_prev;

    always_comb begin
        st_next          = st_reg;
        st_next.ack_prev = pins_sync.status.ack_n;
        // Write data phase lands before the next read so a read right
        // after a write sees the new value without a wait state
        if (st_reg.ph_valid && st_reg.ph_write) begin
            case (st_reg.ph_idx)
                bpp_pkg::DATA_IDX: begin
                    st_next.data_reg = hwdata[7:0];
                end
                bpp_pkg::CONTROL_IDX: begin
                    st_next.ctrl_reg = hwdata[7:0] & bpp_pkg::CTRL_WR_MASK;
                end
                default: begin
                    st_next.ctrl_reg = st_reg.ctrl_reg;
                end
            endcase
        end
        st_next.ph_valid = addr_take && bpp_mapped(haddr);
        st_next.ph_write = hwrite;
        st_next.ph_idx   = haddr[bpp_pkg::IDX_MSB:bpp_pkg::IDX_LSB];
        if (addr_take) begin
            st_next.rdata = 32'h00000000;
        end
        if (rd_take) begin
            st_next.rdata = {24'h000000,
                             bpp_read_value(haddr[bpp_pkg::IDX_MSB:bpp_pkg::IDX_LSB],
                                            st_next.data_reg, st_next.ctrl_reg,
                                            st_reg.flag_reg, extended_mode_pin, pins_sync)};
        end
        if (rd_take && haddr[bpp_pkg::IDX_MSB:bpp_pkg::IDX_LSB] == bpp_pkg::STATUS_IDX) begin
            st_next.flag_reg = 1'b1;
        end
        // A release coinciding with a status read still clears the flag
        if (ack_release && st_reg.ctrl_reg[bpp_pkg::CTRL_IRQ_EN]) begin
            st_next.flag_reg = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg          <= '0;
            st_reg.data_reg <= bpp_pkg::DATA_RESET;
            st_reg.ctrl_reg <= bpp_pkg::CTRL_RESET;
            st_reg.flag_reg <= bpp_pkg::FLAG_RESET;
            st_reg.ack_prev <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Zero wait states, never an error
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st_reg.rdata;

    assign parallel_data_lines_out  = st_reg.data_reg;
    // Direction is ignored in compatibility mode
    assign parallel_data_lines_oe_n = extended_mode_pin && st_reg.ctrl_reg[bpp_pkg::CTRL_DIR];

    assign data_strobe_n    = !st_reg.ctrl_reg[bpp_pkg::CTRL_STROBE];
    assign auto_line_feed_n = !st_reg.ctrl_reg[bpp_pkg::CTRL_FEED];
    assign printer_init_n   = st_reg.ctrl_reg[bpp_pkg::CTRL_INIT];
    assign select_in_line_n = !st_reg.ctrl_reg[bpp_pkg::CTRL_SEL_IN];

    // High while the flag shows a pending acknowledge
    assign port_irq_output = !st_reg.flag_reg;
    assign port_irq_oe_n   = !st_reg.ctrl_reg[bpp_pkg::CTRL_IRQ_EN];

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic pend_wr;
    assign pend_wr = st_reg.ph_valid && st_reg.ph_write;

    a_compat_readback: assert property (
        rd_take && !extended_mode_pin && !pend_wr &&
        haddr[bpp_pkg::IDX_MSB:bpp_pkg::IDX_LSB] == bpp_pkg::DATA_IDX
        |=> hrdata[7:0] == $past(st_reg.data_reg)
    ) else $error("compat data read did not return latch");

    a_compat_drive: assert property (
        pend_wr && st_reg.ph_idx == bpp_pkg::DATA_IDX && !extended_mode_pin
        |=> !parallel_data_lines_oe_n && parallel_data_lines_out == $past(hwdata[7:0])
    ) else $error("compat write not driven on data lines");

    a_ext_read_lines: assert property (
        rd_take && extended_mode_pin && st_reg.ctrl_reg[bpp_pkg::CTRL_DIR] && !pend_wr &&
        haddr[bpp_pkg::IDX_MSB:bpp_pkg::IDX_LSB] == bpp_pkg::DATA_IDX
        |=> hrdata[7:0] == $past(pins_sync.lines)
    ) else $error("extended input read did not return lines");

    a_ext_latch_write: assert property (
        pend_wr && st_reg.ph_idx == bpp_pkg::DATA_IDX && extended_mode_pin
        |=> st_reg.data_reg == $past(hwdata[7:0])
    ) else $error("extended write did not update latch");

    a_dir_release: assert property (
        extended_mode_pin && st_reg.ctrl_reg[bpp_pkg::CTRL_DIR] |-> parallel_data_lines_oe_n
    ) else $error("data lines driven while direction is input");

    a_status_fixed: assert property (
        rd_take && haddr[bpp_pkg::IDX_MSB:bpp_pkg::IDX_LSB] == bpp_pkg::STATUS_IDX
        |=> hrdata[1:0] == 2'h3 && hrdata[7:3] == $past(pins_sync.status)
    ) else $error("status read wrong fixed or input bits");

    a_flag_clear: assert property (
        ack_release && st_reg.ctrl_reg[bpp_pkg::CTRL_IRQ_EN]
        |=> !st_reg.flag_reg ##0 port_irq_output
    ) else $error("acknowledge release did not clear flag");

    a_flag_set_read: assert property (
        rd_take && haddr[bpp_pkg::IDX_MSB:bpp_pkg::IDX_LSB] == bpp_pkg::STATUS_IDX &&
        !(ack_release && st_reg.ctrl_reg[bpp_pkg::CTRL_IRQ_EN])
        |=> st_reg.flag_reg
    ) else $error("status read did not set flag");

    a_ctrl_pins: assert property (
        pend_wr && st_reg.ph_idx == bpp_pkg::CONTROL_IDX
        |=> data_strobe_n == !$past(hwdata[0]) && auto_line_feed_n == !$past(hwdata[1]) &&
            printer_init_n == $past(hwdata[2]) && select_in_line_n == !$past(hwdata[3])
    ) else $error("control pins do not follow written bits");

    a_irq_float: assert property (
        pend_wr && st_reg.ph_idx == bpp_pkg::CONTROL_IDX && !hwdata[4] ##1
        !(pend_wr && st_reg.ph_idx == bpp_pkg::CONTROL_IDX && hwdata[4])
        |-> port_irq_oe_n ##1 port_irq_oe_n
    ) else $error("interrupt driven while disabled");

    a_ctrl_readback: assert property (
        pend_wr && st_reg.ph_idx == bpp_pkg::CONTROL_IDX ##1
        rd_take && !pend_wr && haddr[bpp_pkg::IDX_MSB:bpp_pkg::IDX_LSB] == bpp_pkg::CONTROL_IDX
        |=> hrdata == {24'h000000, 2'h0, $past(hwdata[5:0], 2)}
    ) else $error("control read differs from last write");

    // Registers move only on their own writes
    a_data_hold: assert property (
        !(pend_wr && st_reg.ph_idx == bpp_pkg::DATA_IDX) |=> $stable(st_reg.data_reg)
    ) else $error("data latch changed without a data write");

    a_ctrl_hold: assert property (
        !(pend_wr && st_reg.ph_idx == bpp_pkg::CONTROL_IDX) |=> $stable(st_reg.ctrl_reg)
    ) else $error("control changed without a control write");

    a_status_wr_ignored: assert property (
        pend_wr && st_reg.ph_idx == bpp_pkg::STATUS_IDX
        |=> $stable(st_reg.data_reg) && $stable(st_reg.ctrl_reg)
    ) else $error("status write changed a register");

    a_ctrl_reserved: assert property (
        st_reg.ctrl_reg[7:6] == 2'h0
    ) else $error("reserved control bits set");

    a_irq_enable: assert property (
        pend_wr && st_reg.ph_idx == bpp_pkg::CONTROL_IDX && hwdata[4] |=> !port_irq_oe_n
    ) else $error("interrupt not driven while enabled");

    a_compat_driven: assert property (
        !extended_mode_pin |-> !parallel_data_lines_oe_n
    ) else $error("data lines released in compat mode");

    a_flag_hold: assert property (
        !(rd_take && haddr[bpp_pkg::IDX_MSB:bpp_pkg::IDX_LSB] == bpp_pkg::STATUS_IDX) && !ack_release
        |=> $stable(st_reg.flag_reg)
    ) else $error("flag moved with no read and no release");

    a_release_ignored: assert property (
        ack_release && !st_reg.ctrl_reg[bpp_pkg::CTRL_IRQ_EN] |=> !$fell(st_reg.flag_reg)
    ) else $error("flag cleared while interrupts disabled");

    a_flag_read_value: assert property (
        rd_take && haddr[bpp_pkg::IDX_MSB:bpp_pkg::IDX_LSB] == bpp_pkg::STATUS_IDX
        |=> hrdata[2] == $past(st_reg.flag_reg)
    ) else $error("status read did not show the flag");

    a_reset_values: assert property (
        $rose(hresetn) |-> st_reg.flag_reg && st_reg.data_reg == bpp_pkg::DATA_RESET &&
                           st_reg.ctrl_reg == bpp_pkg::CTRL_RESET
    ) else $error("registers not at reset values after reset");

    // Two flops of delay, judged only once reset is two edges behind
    a_sync_delay: assert property (
        $past(hresetn, 2) |-> pins_sync == $past(pins_async, 2)
    ) else $error("printer inputs not passed through two flops");

    a_unmapped_read: assert property (
        addr_take && !hwrite && !bpp_mapped(haddr) |=> hrdata == 32'h00000000
    ) else $error("unmapped read returned nonzero data");

    a_read_upper: assert property (
        rd_take |=> hrdata[31:8] == 24'h000000
    ) else $error("read data above the byte not zero");

    // Read data must stand until the master takes the next address phase
    a_read_hold: assert property (
        !addr_take |=> $stable(hrdata)
    ) else $error("read data changed between transfers");

    c_ext_input_read: cover property (
        rd_take && extended_mode_pin && st_reg.ctrl_reg[bpp_pkg::CTRL_DIR]
    );

    c_flag_cleared: cover property (
        st_reg.flag_reg ##1 !st_reg.flag_reg ##[1:20] st_reg.flag_reg
    );

    c_compat_write: cover property (
        pend_wr && st_reg.ph_idx == bpp_pkg::DATA_IDX && !extended_mode_pin
    );

    c_ctrl_readback: cover property (
        pend_wr && st_reg.ph_idx == bpp_pkg::CONTROL_IDX ##1 rd_take
    );

    c_release_ignored: cover property (
        ack_release && !st_reg.ctrl_reg[bpp_pkg::CTRL_IRQ_EN]
    );

endmodule : bpp_port

// ==== hw/bpp_sync.sv ====
`timescale 1ns/1ns

module bpp_sync (
    // Clock and reset
    input  wire logic               hclk,
    input  wire logic               hresetn,
    // Asynchronous pins in, synchronous copy out
    input  wire bpp_pkg::bpp_pins_t pins_async,
    output bpp_pkg::bpp_pins_t      pins_sync
);

    bpp_pkg::bpp_sync_state_t st_reg;
    bpp_pkg::bpp_sync_state_t st_next;

    // First stage feeds only the second stage
    always_comb begin
        st_next        = st_reg;
        st_next.first  = pins_async;
        st_next.second = st_reg.first;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
            // Acknowledge idles high; a low copy here would fake a release
            st_reg.first.status.ack_n  <= 1'b1;
            st_reg.second.status.ack_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pins_sync = st_reg.second;

endmodule : bpp_sync
